// ==== core/qmc_pkg.sv ====
// Constants shared by the modulation and calibration questionable status groups.
package qmc_pkg;
  localparam int          REG_W         = 16;
  localparam int          SEL_W         = 4;
  // Command selectors for the query and write port.
  localparam logic [3:0]  SEL_MOD_COND  = 4'h0;
  localparam logic [3:0]  SEL_MOD_PTR   = 4'h1;
  localparam logic [3:0]  SEL_MOD_NTR   = 4'h2;
  localparam logic [3:0]  SEL_MOD_EVENT = 4'h3;
  localparam logic [3:0]  SEL_MOD_ENA   = 4'h4;
  localparam logic [3:0]  SEL_CAL_COND  = 4'h8;
  localparam logic [3:0]  SEL_CAL_PTR   = 4'h9;
  localparam logic [3:0]  SEL_CAL_NTR   = 4'hA;
  localparam logic [3:0]  SEL_CAL_EVENT = 4'hB;
  localparam logic [3:0]  SEL_CAL_ENA   = 4'hC;
  // Modulation condition bit positions.
  localparam int          MOD_EXT1_UNDER_BIT = 0;
  localparam int          MOD_EXT1_OVER_BIT  = 1;
  localparam int          MOD_EXT2_UNDER_BIT = 2;
  localparam int          MOD_EXT2_OVER_BIT  = 3;
  localparam int          MOD_UNCAL_BIT      = 4;
  // Calibration condition bit positions, full and reduced layouts.
  localparam int          CAL_IQ_FAIL_BIT       = 0;
  localparam int          CAL_ZERO_FAIL_BIT     = 1;
  localparam int          CAL_RED_ZERO_FAIL_BIT = 0;
  // Bits that can ever be set in each layout.
  localparam logic [15:0] MOD_IMPL_MASK     = 16'h001F;
  localparam logic [15:0] CAL_FULL_MASK     = 16'h0003;
  localparam logic [15:0] CAL_RED_MASK      = 16'h0001;
  // Parent questionable condition summary positions.
  localparam int          PARENT_MOD_BIT    = 7;
  localparam int          PARENT_CAL_BIT    = 8;
  // Reset values of the writable registers.
  localparam logic [15:0] PTR_RESET         = 16'hFFFF;
  localparam logic [15:0] NTR_RESET         = 16'h0000;
  localparam logic [15:0] ENA_RESET         = 16'h0000;
endpackage

// ==== core/qmc_status.sv ====
// Modulation and calibration questionable status groups with their query port.
// How it works
// - Modulation condition bits 0..4: ext1 under/over, ext2 under/over, uncalibrated.
// - Modulation condition bits 5 to 15 always read zero.
// - Condition registers track live inputs each cycle and ignore writes.
// - Positive filter passes 0-to-1 changes, negative filter passes 1-to-0 changes.
// - An enabled transition sets the event bit, which then holds.
// - Reading an event register returns its contents then clears it.
// - Modulation enable selects event bits feeding parent bit 7.
// - Values written and returned are plain binary weighted sums of bits.
// - Full calibration layout: bit 0 I/Q failure, bit 1 zero-calibration failure.
// - Full calibration layout: bits 2 to 15 always read zero.
// - Reduced calibration layout: bit 0 zero-calibration failure, others zero.
// - Calibration summary drives parent bit 8.
// - Absent groups read zero on every query; absent bits read zero in the condition and event registers.
// - Calibration has its own filters and read-cleared event register.
// - Calibration enable selects event bits feeding the calibration summary.
`timescale 1ns/100ps

module qmc_group #(
  parameter logic [15:0] IMPL_MASK = 16'h0000
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [15:0] live_cond,
  input  wire logic        wr_ptr,
  input  wire logic        wr_ntr,
  input  wire logic        wr_ena,
  input  wire logic [15:0] wdata,
  input  wire logic        rd_event,
  output logic      [15:0] cond,
  output logic      [15:0] ptr,
  output logic      [15:0] ntr,
  output logic      [15:0] event_bits,
  output logic      [15:0] enable,
  output logic             summary
);
  logic [15:0] next_cond;
  logic [15:0] trans_set;

  // Unused positions are forced low here so no event can ever arise on them.
  assign next_cond = live_cond & IMPL_MASK;
  assign trans_set = (next_cond & ~cond & ptr)
                   | (~next_cond & cond & ntr);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cond <= 16'h0000;
    end else begin
      cond <= next_cond;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ptr    <= qmc_pkg::PTR_RESET;
      ntr    <= qmc_pkg::NTR_RESET;
      enable <= qmc_pkg::ENA_RESET;
    end else begin
      if (wr_ptr) begin
        ptr <= wdata;
      end
      if (wr_ntr) begin
        ntr <= wdata;
      end
      if (wr_ena) begin
        enable <= wdata;
      end
    end
  end

  // A transition landing in the read cycle survives the clear, so it is never lost.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      event_bits <= 16'h0000;
    end else if (rd_event) begin
      event_bits <= trans_set;
    end else begin
      event_bits <= event_bits | trans_set;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      summary <= 1'b0;
    end else begin
      summary <= |(event_bits & enable);
    end
  end

  property p_rise_sets_event;
    @(posedge core_clk) disable iff (!nrst)
      (next_cond[0] && !cond[0] && ptr[0]) |=> event_bits[0];
  endproperty
  a_rise_sets_event: assert property (p_rise_sets_event) else $error("rise did not set event");

  property p_fall_sets_event;
    @(posedge core_clk) disable iff (!nrst)
      (!next_cond[1] && cond[1] && ntr[1]) |=> event_bits[1];
  endproperty
  a_fall_sets_event: assert property (p_fall_sets_event) else $error("fall did not set event");

  property p_event_holds;
    @(posedge core_clk) disable iff (!nrst)
      (event_bits[0] && !rd_event) |=> event_bits[0];
  endproperty
  a_event_holds: assert property (p_event_holds) else $error("event bit dropped without read");

  property p_no_spurious_event;
    @(posedge core_clk) disable iff (!nrst)
      (!event_bits[2] && !trans_set[2]) |=> !event_bits[2];
  endproperty
  a_no_spurious_event: assert property (p_no_spurious_event) else $error("event set without transition");

  property p_read_clears;
    @(posedge core_clk) disable iff (!nrst)
      (rd_event && trans_set == 16'h0000) |=> (event_bits == 16'h0000);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("event read did not clear");

  property p_cond_follows;
    @(posedge core_clk) disable iff (!nrst)
      1'b1 |=> (cond == ($past(live_cond) & IMPL_MASK));
  endproperty
  a_cond_follows: assert property (p_cond_follows) else $error("condition did not follow input");

  property p_unused_zero;
    @(posedge core_clk) disable iff (!nrst)
      ((cond & ~IMPL_MASK) == 16'h0000) && ((event_bits & ~IMPL_MASK) == 16'h0000);
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit nonzero");

  property p_summary;
    @(posedge core_clk) disable iff (!nrst)
      ##1 (summary == $past(|(event_bits & enable)));
  endproperty
  a_summary: assert property (p_summary) else $error("summary mismatch");

  property p_write_stores;
    @(posedge core_clk) disable iff (!nrst)
      wr_ena |=> (enable == $past(wdata)) ##1 ($past(wr_ena) || enable == $past(wdata, 2));
  endproperty
  a_write_stores: assert property (p_write_stores) else $error("enable not stored");
endmodule // qmc_group

module qmc_status #(
  parameter bit MOD_GROUP_PRESENT = 1'b1,
  parameter bit CAL_FULL          = 1'b1,
  parameter bit CAL_IQ_PRESENT    = 1'b1,
  parameter bit CAL_ZERO_PRESENT  = 1'b1
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        mod_ext1_under,
  input  wire logic        mod_ext1_over,
  input  wire logic        mod_ext2_under,
  input  wire logic        mod_ext2_over,
  input  wire logic        mod_uncal,
  input  wire logic        cal_iq_fail,
  input  wire logic        cal_dc_freq_phase_mod_zero_fail,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [3:0]  cmd_sel,
  input  wire logic [15:0] cmd_wdata,
  output logic             rsp_valid,
  output logic      [15:0] rsp_data,
  output logic             rsp_error,
  output logic             parent_mod_summary,
  output logic             parent_cal_summary
);
  localparam logic [15:0] MOD_MASK = MOD_GROUP_PRESENT ? qmc_pkg::MOD_IMPL_MASK : 16'h0000;
  localparam logic [15:0] CAL_MASK = CAL_FULL
    ? (qmc_pkg::CAL_FULL_MASK & {14'h0000, CAL_ZERO_PRESENT, CAL_IQ_PRESENT})
    : (qmc_pkg::CAL_RED_MASK & {15'h0000, CAL_ZERO_PRESENT});

  // The reduced layout has no I/Q failure position to carry.
  if (!CAL_FULL && CAL_IQ_PRESENT) begin : g_bad_variant
    $error("reduced calibration layout cannot carry the I/Q failure flag");
  end

  logic [15:0] mod_live;
  logic [15:0] cal_live;
  logic [15:0] mod_cond, mod_ptr, mod_ntr, mod_event, mod_ena;
  logic [15:0] cal_cond, cal_ptr, cal_ntr, cal_event, cal_ena;
  logic        mod_sum;
  logic        cal_sum;
  logic        do_wr;
  logic        do_rd;
  logic [15:0] next_rsp_data;
  logic        next_rsp_error;

  always_comb begin
    mod_live = 16'h0000;
    mod_live[qmc_pkg::MOD_EXT1_UNDER_BIT] = mod_ext1_under;
    mod_live[qmc_pkg::MOD_EXT1_OVER_BIT]  = mod_ext1_over;
    mod_live[qmc_pkg::MOD_EXT2_UNDER_BIT] = mod_ext2_under;
    mod_live[qmc_pkg::MOD_EXT2_OVER_BIT]  = mod_ext2_over;
    mod_live[qmc_pkg::MOD_UNCAL_BIT]      = mod_uncal;
  end

  always_comb begin
    cal_live = 16'h0000;
    if (CAL_FULL) begin
      cal_live[qmc_pkg::CAL_IQ_FAIL_BIT]   = cal_iq_fail;
      cal_live[qmc_pkg::CAL_ZERO_FAIL_BIT] = cal_dc_freq_phase_mod_zero_fail;
    end else begin
      cal_live[qmc_pkg::CAL_RED_ZERO_FAIL_BIT] = cal_dc_freq_phase_mod_zero_fail;
    end
  end

  assign do_wr = cmd_valid && cmd_write;
  assign do_rd = cmd_valid && !cmd_write;

  qmc_group #(.IMPL_MASK(MOD_MASK)) u_mod (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .live_cond  (mod_live),
    .wr_ptr     (do_wr && cmd_sel == qmc_pkg::SEL_MOD_PTR && MOD_GROUP_PRESENT),
    .wr_ntr     (do_wr && cmd_sel == qmc_pkg::SEL_MOD_NTR && MOD_GROUP_PRESENT),
    .wr_ena     (do_wr && cmd_sel == qmc_pkg::SEL_MOD_ENA && MOD_GROUP_PRESENT),
    .wdata      (cmd_wdata),
    .rd_event   (do_rd && cmd_sel == qmc_pkg::SEL_MOD_EVENT),
    .cond       (mod_cond),
    .ptr        (mod_ptr),
    .ntr        (mod_ntr),
    .event_bits (mod_event),
    .enable     (mod_ena),
    .summary    (mod_sum)
  );

  qmc_group #(.IMPL_MASK(CAL_MASK)) u_cal (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .live_cond  (cal_live),
    .wr_ptr     (do_wr && cmd_sel == qmc_pkg::SEL_CAL_PTR),
    .wr_ntr     (do_wr && cmd_sel == qmc_pkg::SEL_CAL_NTR),
    .wr_ena     (do_wr && cmd_sel == qmc_pkg::SEL_CAL_ENA),
    .wdata      (cmd_wdata),
    .rd_event   (do_rd && cmd_sel == qmc_pkg::SEL_CAL_EVENT),
    .cond       (cal_cond),
    .ptr        (cal_ptr),
    .ntr        (cal_ntr),
    .event_bits (cal_event),
    .enable     (cal_ena),
    .summary    (cal_sum)
  );

  assign parent_mod_summary = mod_sum;
  assign parent_cal_summary = cal_sum;

  // Writes to condition or event registers are refused and flagged, never stored.
  always_comb begin
    next_rsp_data  = 16'h0000;
    next_rsp_error = 1'b0;
    case (cmd_sel)
      qmc_pkg::SEL_MOD_COND: begin
        next_rsp_data  = cmd_write ? 16'h0000 : mod_cond;
        next_rsp_error = cmd_write;
      end
      qmc_pkg::SEL_MOD_EVENT: begin
        next_rsp_data  = cmd_write ? 16'h0000 : mod_event;
        next_rsp_error = cmd_write;
      end
      qmc_pkg::SEL_MOD_PTR: begin
        next_rsp_data = (cmd_write || !MOD_GROUP_PRESENT) ? 16'h0000 : mod_ptr;
      end
      qmc_pkg::SEL_MOD_NTR: begin
        next_rsp_data = (cmd_write || !MOD_GROUP_PRESENT) ? 16'h0000 : mod_ntr;
      end
      qmc_pkg::SEL_MOD_ENA: begin
        next_rsp_data = (cmd_write || !MOD_GROUP_PRESENT) ? 16'h0000 : mod_ena;
      end
      qmc_pkg::SEL_CAL_COND: begin
        next_rsp_data  = cmd_write ? 16'h0000 : cal_cond;
        next_rsp_error = cmd_write;
      end
      qmc_pkg::SEL_CAL_EVENT: begin
        next_rsp_data  = cmd_write ? 16'h0000 : cal_event;
        next_rsp_error = cmd_write;
      end
      qmc_pkg::SEL_CAL_PTR: begin
        next_rsp_data = cmd_write ? 16'h0000 : cal_ptr;
      end
      qmc_pkg::SEL_CAL_NTR: begin
        next_rsp_data = cmd_write ? 16'h0000 : cal_ntr;
      end
      qmc_pkg::SEL_CAL_ENA: begin
        next_rsp_data = cmd_write ? 16'h0000 : cal_ena;
      end
      default: begin
        next_rsp_error = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rsp_valid <= 1'b0;
      rsp_data  <= 16'h0000;
      rsp_error <= 1'b0;
    end else begin
      rsp_valid <= cmd_valid;
      rsp_data  <= cmd_valid ? next_rsp_data : 16'h0000;
      rsp_error <= cmd_valid && next_rsp_error;
    end
  end

  property p_event_read_returns_old;
    @(posedge core_clk) disable iff (!nrst)
      (cmd_valid && !cmd_write && cmd_sel == qmc_pkg::SEL_MOD_EVENT) |=> (rsp_valid && rsp_data == $past(mod_event));
  endproperty
  a_event_read_returns_old: assert property (p_event_read_returns_old) else $error("event read data wrong");

  property p_cond_write_ignored;
    @(posedge core_clk) disable iff (!nrst)
      (cmd_valid && cmd_write && cmd_sel == qmc_pkg::SEL_CAL_COND) |=> (rsp_error && rsp_data == 16'h0000);
  endproperty
  a_cond_write_ignored: assert property (p_cond_write_ignored) else $error("condition write not refused");

  property p_mod_high_zero;
    @(posedge core_clk) disable iff (!nrst)
      (mod_cond[15:5] == 11'h000) && (cal_cond[15:2] == 14'h0000);
  endproperty
  a_mod_high_zero: assert property (p_mod_high_zero) else $error("reserved condition bit set");
endmodule // qmc_status

// ==== dv/qmc_tb.sv ====
// Self-checking testbench for the modulation and calibration status groups.
`timescale 1ns/100ps
module testbench;
  logic        core_clk;
  logic        nrst;
  logic [4:0]  mflag;
  logic        cal_iq;
  logic        cal_zero;
  logic        cmd_valid;
  logic        cmd_write;
  logic [3:0]  cmd_sel;
  logic [15:0] cmd_wdata;
  logic        rv_a, re_a, pm_a, pc_a, rv_b, re_b, pm_b, pc_b;
  logic [15:0] rd_a, rd_b, got_a, got_b;
  logic        err_a, err_b;
  int          n_fail;
  int          tests_run;
  int          i;
  localparam logic [3:0]  SELS [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC};
  localparam logic [15:0] RST_A[10] = '{16'h0, 16'hFFFF, 16'h0, 16'h0, 16'h0, 16'h0, 16'hFFFF, 16'h0, 16'h0, 16'h0};
  localparam logic [15:0] RST_B[10] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'hFFFF, 16'h0, 16'h0, 16'h0};

  qmc_status qmc_status_i (
    .core_clk(core_clk), .nrst(nrst), .mod_ext1_under(mflag[0]), .mod_ext1_over(mflag[1]),
    .mod_ext2_under(mflag[2]), .mod_ext2_over(mflag[3]), .mod_uncal(mflag[4]), .cal_iq_fail(cal_iq),
    .cal_dc_freq_phase_mod_zero_fail(cal_zero), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .rsp_valid(rv_a), .rsp_data(rd_a), .rsp_error(re_a),
    .parent_mod_summary(pm_a), .parent_cal_summary(pc_a));

  // Second build: no modulation group and the reduced calibration layout, fed the same stimulus.
  qmc_status #(.MOD_GROUP_PRESENT(1'b0), .CAL_FULL(1'b0), .CAL_IQ_PRESENT(1'b0)) qmc_status_red_i (
    .core_clk(core_clk), .nrst(nrst), .mod_ext1_under(mflag[0]), .mod_ext1_over(mflag[1]),
    .mod_ext2_under(mflag[2]), .mod_ext2_over(mflag[3]), .mod_uncal(mflag[4]), .cal_iq_fail(cal_iq),
    .cal_dc_freq_phase_mod_zero_fail(cal_zero), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata), .rsp_valid(rv_b), .rsp_data(rd_b), .rsp_error(re_b),
    .parent_mod_summary(pm_b), .parent_cal_summary(pc_b));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One command: strobe for one edge, answer sampled one cycle later.
  // A cycle is left idle first so the strobe never toggles twice in one step.
  task automatic cmd(input logic wr, input logic [3:0] sel, input logic [15:0] wd);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_sel   = sel;
    cmd_wdata = wd;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    chk({14'h0, rv_a, rv_b}, 16'h0003);
    got_a = rd_a;
    got_b = rd_b;
    err_a = re_a;
    err_b = re_b;
  endtask

  task automatic rd(input logic [3:0] sel, input logic [15:0] exp_a, input logic [15:0] exp_b);
    cmd(1'b0, sel, 16'h0000);
    chk(got_a, exp_a);
    chk(got_b, exp_b);
  endtask

  task automatic wr(input logic [3:0] sel, input logic [15:0] val, input logic exp_err);
    cmd(1'b1, sel, val);
    chk({14'h0, err_a, err_b}, {14'h0, exp_err, exp_err});
    // A write returns zero in the low byte from both builds, whether it was stored or refused.
    chk({got_a[7:0], got_b[7:0]}, 16'h0000);
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    n_fail = 0;
    tests_run = 0;
    nrst = 1'b0;
    mflag = 5'h00;
    cal_iq = 1'b0;
    cal_zero = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_sel = 4'h0;
    cmd_wdata = 16'h0000;
    settle(2);
    nrst = 1'b1;
    for (i = 0; i < 10; i++) begin
      rd(SELS[i], RST_A[i], RST_B[i]);
    end
    @(negedge core_clk);
    mflag = 5'h1F;
    cal_iq = 1'b1;
    cal_zero = 1'b1;
    rd(qmc_pkg::SEL_MOD_COND, 16'h001F, 16'h0000);
    rd(qmc_pkg::SEL_CAL_COND, 16'h0003, 16'h0001);
    rd(qmc_pkg::SEL_MOD_EVENT, 16'h001F, 16'h0000);
    rd(qmc_pkg::SEL_MOD_EVENT, 16'h0000, 16'h0000);
    wr(qmc_pkg::SEL_MOD_COND, 16'hFFFF, 1'b1);
    rd(qmc_pkg::SEL_MOD_COND, 16'h001F, 16'h0000);
    wr(4'h5, 16'h0001, 1'b1);
    wr(qmc_pkg::SEL_MOD_PTR, 16'h0000, 1'b0);
    wr(qmc_pkg::SEL_MOD_NTR, 16'h0005, 1'b0);
    rd(qmc_pkg::SEL_MOD_NTR, 16'h0005, 16'h0000);
    @(negedge core_clk);
    mflag = 5'h00;
    rd(qmc_pkg::SEL_MOD_EVENT, 16'h0005, 16'h0000);
    wr(qmc_pkg::SEL_MOD_ENA, 16'h0018, 1'b0);
    rd(qmc_pkg::SEL_MOD_ENA, 16'h0018, 16'h0000);
    wr(qmc_pkg::SEL_MOD_PTR, 16'hFFFF, 1'b0);
    @(negedge core_clk);
    mflag = 5'h01;
    settle(2);
    chk({15'h0, pm_a}, 16'h0000);
    mflag = 5'h11;
    settle(2);
    chk({14'h0, pm_a, pm_b}, 16'h0002);
    rd(qmc_pkg::SEL_MOD_EVENT, 16'h0011, 16'h0000);
    settle(1);
    chk({15'h0, pm_a}, 16'h0000);
    wr(qmc_pkg::SEL_CAL_ENA, 16'h0002, 1'b0);
    settle(1);
    chk({14'h0, pc_a, pc_b}, 16'h0002);
    rd(qmc_pkg::SEL_CAL_EVENT, 16'h0003, 16'h0001);
    settle(1);
    chk({15'h0, pc_a}, 16'h0000);
    wr(qmc_pkg::SEL_CAL_NTR, 16'h0001, 1'b0);
    @(negedge core_clk);
    cal_iq = 1'b0;
    cal_zero = 1'b0;
    rd(qmc_pkg::SEL_CAL_EVENT, 16'h0001, 16'h0001);
    report_and_stop();
  end
endmodule // testbench
